// >>> src/plpc_pkg.sv
// Purpose: Shared constants and types for the pump peripheral control logic
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes:   Port offsets are byte addresses on the latched low address byte
package plpc_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_KHZ          = 200000;
   localparam int ADC_CLK_KHZ      = 1333;
   localparam int ADC_HALF_CYCLES  = CLK_KHZ / (2 * ADC_CLK_KHZ);
   localparam int STROBE_NS        = 100;
   localparam int STROBE_CYCLES    = (STROBE_NS * CLK_KHZ + 999999) / 1000000;
   localparam int NMI_RESET_MS     = 3000;
   localparam int NMI_RESET_CYCLES = NMI_RESET_MS * CLK_KHZ;
   localparam int STEP_TICK_US     = 10;
   localparam int STEP_TICK_CYCLES = (STEP_TICK_US * CLK_KHZ) / 1000;

   // ****************************************************************
   // Port map
   // ****************************************************************
   localparam logic [7:0] PORT_ADC_CTRL   = 8'h00;
   localparam logic [7:0] PORT_ADC_CHAN   = 8'h01;
   localparam logic [7:0] PORT_ADC_LOW    = 8'h02;
   localparam logic [7:0] PORT_ADC_HIGH   = 8'h03;
   localparam logic [7:0] PORT_DAC        = 8'h04;
   localparam logic [7:0] PORT_SENSE_EN   = 8'h05;
   localparam logic [7:0] PORT_SENSE_IN   = 8'h06;
   localparam logic [7:0] PORT_MOTOR_RATE = 8'h07;
   localparam logic [3:0] IO_SEGMENT      = 4'hF;

   localparam int CTRL_CLK_EN = 0;
   localparam int CTRL_GO     = 1;
   localparam int CTRL_CAL    = 2;

   localparam int STB_GO      = 0;
   localparam int STB_CAL     = 1;
   localparam int STB_CHAN    = 2;
   localparam int STB_DAC     = 3;
   localparam int NUM_STROBES = 4;

   localparam int MOTOR_PHASES = 5;
   localparam logic [4:0] PHASE_START = 5'h03;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic       ale;
      logic       rd_n;
      logic       wr_n;
      logic       select_n;
      logic [3:0] upper;
      logic [7:0] data;
   } plpc_bus_in_t;

   typedef struct packed {
      logic pressureSupply;
      logic latchSenseEnable;
      logic rotationEmitterOn;
      logic bubbleTest_n;
      logic bubbleDetectorPower;
   } plpc_sense_en_t;

   localparam logic [4:0] SENSE_EN_RESET = 5'h02;

   typedef struct packed {
      logic door;
      logic bubble;
      logic encoder;
      logic clamp;
      logic displaySync;
   } plpc_sense_in_t;

   typedef enum logic [1:0] {
      WD_RUN  = 2'b00,
      WD_NMI  = 2'b01,
      WD_HOLD = 2'b11
   } plpc_wd_state_t;

endpackage : plpc_pkg

// >>> src/plpc_phase_gen.sv
// Purpose: Five-phase stepper drive pattern generator
// Assumes: stepPulse is a one-cycle enable
// Notes:   Outputs are registered and go all low on the clock after run goes low
`timescale 1ns/100ps
`default_nettype none
module plpc_phase_gen #(
   parameter int PHASES = plpc_pkg::MOTOR_PHASES
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              run,
   input  wire logic              stepPulse,
   output var  logic [PHASES-1:0] phase
);

   logic [PHASES-1:0] pattern;
   wire  [PHASES-1:0] next_pattern = {pattern[PHASES-2:0], pattern[PHASES-1]};

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // rotate on step
   always_ff @(posedge clock) begin
      if (rst) begin
         pattern <= PHASES'(plpc_pkg::PHASE_START);
         phase   <= '0;
      end else begin
         if (run && stepPulse) begin
            pattern <= next_pattern;
         end
         phase <= run ? pattern : '0;
      end
   end

endmodule : plpc_phase_gen
`default_nettype wire

// >>> src/plpc_peripheral_control.sv
// Purpose: Processor bus glue, converter sequencing, DAC strobe, watchdog, sensors
// Assumes: Bus pins synchronous to clock; one clock domain
// Notes:   Notes on behaviour follow
`timescale 1ns/100ps
`default_nettype none
module plpc_peripheral_control #(
   parameter int unsigned NMI_RESET_CYCLES = plpc_pkg::NMI_RESET_CYCLES,
   parameter int unsigned STEP_TICK_CYCLES = plpc_pkg::STEP_TICK_CYCLES,
   parameter int unsigned ADC_HALF_CYCLES  = plpc_pkg::ADC_HALF_CYCLES,
   parameter int unsigned STROBE_CYCLES    = plpc_pkg::STROBE_CYCLES
) (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire plpc_pkg::plpc_bus_in_t   busIn,
   output var  logic [7:0]               adOut,
   output var  logic                     adOe,
   input  wire logic                     supervisorReset_n,
   input  wire logic                     watchdogExpired_n,
   output var  logic                     processorReset_n,
   output var  logic                     nonmaskableIrq,
   output var  logic                     adcClock,
   output wire logic                     adcGoStrobe_n,
   output wire logic                     adcCalStrobe_n,
   output wire logic                     adcChanStrobe_n,
   output var  logic [7:0]               adcChannel,
   input  wire logic                     adcBusy,
   input  wire logic [11:0]              adcResult,
   output wire logic                     dacWrite_n,
   output var  logic [7:0]               motorDriveLevel,
   input  wire logic                     hwFailure,
   output var  plpc_pkg::plpc_sense_en_t senseEn,
   input  wire plpc_pkg::plpc_sense_in_t senseIn,
   output var  logic                     airPresent,
   output wire logic [4:0]               motorPhase
);

   localparam int WD_W   = $clog2(NMI_RESET_CYCLES + 1);
   localparam int TICK_W = $clog2(STEP_TICK_CYCLES + 1);
   localparam int DIV_W  = $clog2(ADC_HALF_CYCLES + 1);
   localparam int STB_W  = $clog2(STROBE_CYCLES + 1);
   localparam logic [WD_W-1:0]   WD_LAST   = WD_W'(NMI_RESET_CYCLES - 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_TICK_CYCLES - 1);
   localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(ADC_HALF_CYCLES - 1);
   localparam logic [STB_W-1:0]  STB_LOAD  = STB_W'(STROBE_CYCLES);

   // ****************************************************************
   // Bus demultiplexing
   // ****************************************************************
   logic [7:0] addrLow;
   logic [3:0] addrHigh;
   logic       wrPrev;

   always_ff @(posedge clock) begin
      if (rst) begin
         addrLow  <= 8'h00;
         addrHigh <= 4'h0;
         wrPrev   <= 1'b1;
      end else begin
         if (busIn.ale) begin
            addrLow  <= busIn.data;
            addrHigh <= busIn.upper;
         end
         wrPrev <= busIn.wr_n;
      end
   end

   wire selected  = !busIn.select_n && !busIn.ale && (addrHigh == plpc_pkg::IO_SEGMENT);
   wire writeTake = selected && wrPrev && !busIn.wr_n;
   wire readOn    = selected && !busIn.rd_n;
   wire wrCtrl    = writeTake && (addrLow == plpc_pkg::PORT_ADC_CTRL);
   wire wrChan    = writeTake && (addrLow == plpc_pkg::PORT_ADC_CHAN);
   wire wrDac     = writeTake && (addrLow == plpc_pkg::PORT_DAC);
   wire wrSense   = writeTake && (addrLow == plpc_pkg::PORT_SENSE_EN);
   wire wrRate    = writeTake && (addrLow == plpc_pkg::PORT_MOTOR_RATE);
   wire rdLow     = readOn && (addrLow == plpc_pkg::PORT_ADC_LOW);

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic       adcClockOn;
   logic [7:0] dacValue;
   logic [7:0] motorRate;
   logic [3:0] resultHigh;
   logic       failPrev;

   always_ff @(posedge clock) begin
      if (rst) begin
         adcClockOn <= 1'b0;
         adcChannel <= 8'h00;
         dacValue   <= 8'h00;
         motorRate  <= 8'h00;
         senseEn    <= plpc_pkg::SENSE_EN_RESET;
         resultHigh <= 4'h0;
         failPrev   <= 1'b0;
      end else begin
         if (wrCtrl) begin
            adcClockOn <= busIn.data[plpc_pkg::CTRL_CLK_EN];
         end
         if (wrChan) begin
            adcChannel <= busIn.data;
         end
         if (wrDac) begin
            dacValue <= busIn.data;
         end
         if (wrRate) begin
            motorRate <= busIn.data;
         end
         if (wrSense) begin
            senseEn <= plpc_pkg::plpc_sense_en_t'(busIn.data[4:0]);
         end
         // high nibble held at low read
         if (rdLow) begin
            resultHigh <= adcResult[11:8];
         end
         failPrev <= hwFailure;
      end
   end

   // ****************************************************************
   // Strobes
   // ****************************************************************
   logic [plpc_pkg::NUM_STROBES-1:0] strobeReq;
   logic [plpc_pkg::NUM_STROBES-1:0] strobeN;

   wire goReq  = wrCtrl && busIn.data[plpc_pkg::CTRL_GO] && adcClockOn;
   wire calReq = wrCtrl && busIn.data[plpc_pkg::CTRL_CAL] && adcClockOn;

   assign strobeReq[plpc_pkg::STB_GO]   = goReq;
   assign strobeReq[plpc_pkg::STB_CAL]  = calReq;
   assign strobeReq[plpc_pkg::STB_CHAN] = wrChan;
   assign strobeReq[plpc_pkg::STB_DAC]  = wrDac || (hwFailure && !failPrev);

   genvar gi;
   generate
      for (gi = 0; gi < plpc_pkg::NUM_STROBES; gi++) begin : gStrobe
         logic [STB_W-1:0] count;
         wire  [STB_W-1:0] next_count = (strobeReq[gi] && count == '0) ? STB_LOAD :
                                        (count != '0) ? count - STB_W'(1) : '0;
         always_ff @(posedge clock) begin
            if (rst) begin
               count       <= '0;
               strobeN[gi] <= 1'b1;
            end else begin
               count       <= next_count;
               strobeN[gi] <= (next_count == '0);
            end
         end
      end
   endgenerate

   assign adcCalStrobe_n  = strobeN[plpc_pkg::STB_CAL];
   assign adcGoStrobe_n   = strobeN[plpc_pkg::STB_GO];
   assign adcChanStrobe_n = strobeN[plpc_pkg::STB_CHAN];
   assign dacWrite_n      = strobeN[plpc_pkg::STB_DAC];

   // ****************************************************************
   // Converter clock
   // ****************************************************************
   logic [DIV_W-1:0] divCount;

   always_ff @(posedge clock) begin
      if (rst || !adcClockOn) begin
         divCount <= '0;
         adcClock <= 1'b0;
      end else if (divCount == DIV_LAST) begin
         divCount <= '0;
         adcClock <= !adcClock;
      end else begin
         divCount <= divCount + DIV_W'(1);
      end
   end

   // ****************************************************************
   // Sensors
   // ****************************************************************
   // bubble validity
   wire bubbleValid = senseEn.bubbleDetectorPower && !senseEn.bubbleTest_n;
   wire latchValid  = senseEn.latchSenseEnable;
   wire encValid    = senseEn.rotationEmitterOn;
   wire pressValid  = senseEn.pressureSupply;

   // ****************************************************************
   // Read port
   // ****************************************************************
   // sensor input port
   wire [7:0] senseRead = {encValid, latchValid, bubbleValid, senseIn.door, senseIn.bubble,
                           senseIn.encoder, senseIn.clamp, senseIn.displaySync};
   wire [7:0] ctrlRead  = {5'h00, pressValid, adcClockOn, adcBusy};
   wire [7:0] readData  =
      (addrLow == plpc_pkg::PORT_ADC_CTRL)   ? ctrlRead :
      (addrLow == plpc_pkg::PORT_ADC_CHAN)   ? adcChannel :
      (addrLow == plpc_pkg::PORT_ADC_LOW)    ? adcResult[7:0] :
      (addrLow == plpc_pkg::PORT_ADC_HIGH)   ? {4'h0, resultHigh} :
      (addrLow == plpc_pkg::PORT_DAC)        ? dacValue :
      (addrLow == plpc_pkg::PORT_SENSE_EN)   ? {3'h0, senseEn} :
      (addrLow == plpc_pkg::PORT_SENSE_IN)   ? senseRead :
      (addrLow == plpc_pkg::PORT_MOTOR_RATE) ? motorRate : 8'h00;

   always_ff @(posedge clock) begin
      if (rst) begin
         adOut <= 8'h00;
         adOe  <= 1'b0;
      end else begin
         adOut <= readOn ? readData : 8'h00;
         adOe  <= readOn;
      end
   end

   // ****************************************************************
   // Watchdog and processor reset
   // ****************************************************************
   plpc_pkg::plpc_wd_state_t wdState;
   plpc_pkg::plpc_wd_state_t next_wdState;
   logic [WD_W-1:0]          wdCount;

   assign next_wdState =
      !supervisorReset_n                                     ? plpc_pkg::WD_RUN :
      (wdState == plpc_pkg::WD_RUN && !watchdogExpired_n)    ? plpc_pkg::WD_NMI :
      (wdState == plpc_pkg::WD_NMI && wdCount == WD_LAST)    ? plpc_pkg::WD_HOLD :
      wdState;

   always_ff @(posedge clock) begin
      if (rst) begin
         wdState          <= plpc_pkg::WD_RUN;
         wdCount          <= '0;
         nonmaskableIrq   <= 1'b0;
         processorReset_n <= 1'b0;
      end else begin
         wdState          <= next_wdState;
         wdCount          <= (wdState == plpc_pkg::WD_NMI) ? wdCount + WD_W'(1) : '0;
         nonmaskableIrq   <= (next_wdState == plpc_pkg::WD_NMI);
         processorReset_n <= supervisorReset_n && (next_wdState != plpc_pkg::WD_HOLD);
      end
   end

   // ****************************************************************
   // Motor
   // ****************************************************************
   logic [TICK_W-1:0] tickCount;
   logic [7:0]        stepCount;
   logic              stepPulse;
   logic              motorRun;

   wire tick = (tickCount == TICK_LAST);

   always_ff @(posedge clock) begin
      if (rst) begin
         tickCount  <= '0;
         stepCount  <= 8'h00;
         stepPulse  <= 1'b0;
         airPresent <= 1'b0;
         motorRun   <= 1'b0;
      end else begin
         tickCount <= tick ? '0 : tickCount + TICK_W'(1);
         if (tick) begin
            stepCount <= (stepCount >= motorRate - 8'h01) ? 8'h00 : stepCount + 8'h01;
         end
         stepPulse  <= tick && (motorRate != 8'h00) && (stepCount >= motorRate - 8'h01);
         airPresent <= bubbleValid && senseIn.bubble;
         motorRun   <= (motorRate != 8'h00) && !hwFailure && !(bubbleValid && senseIn.bubble);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         motorDriveLevel <= 8'h00;
      end else begin
         motorDriveLevel <= hwFailure ? 8'h00 : dacValue;
      end
   end

   plpc_phase_gen #(
      .PHASES    (plpc_pkg::MOTOR_PHASES)
   ) uPhase (
      .clock     (clock),
      .rst       (rst),
      .run       (motorRun),
      .stepPulse (stepPulse),
      .phase     (motorPhase)
   );

endmodule : plpc_peripheral_control
`default_nettype wire

// >>> verif/plpc_pc_assertions.sv
// Purpose: Concurrent checks on the pump peripheral control ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module plpc_pc_assertions #(
   parameter int unsigned NMI_RESET_CYCLES = 50,
   parameter int unsigned ADC_HALF_CYCLES  = 75,
   parameter int unsigned STROBE_CYCLES    = 20
) (
   input wire logic                     clock,
   input wire logic                     rst,
   input wire plpc_pkg::plpc_bus_in_t   busIn,
   input wire logic [7:0]               adOut,
   input wire logic                     adOe,
   input wire logic                     supervisorReset_n,
   input wire logic                     watchdogExpired_n,
   input wire logic                     processorReset_n,
   input wire logic                     nonmaskableIrq,
   input wire logic                     adcClock,
   input wire logic                     adcGoStrobe_n,
   input wire logic                     adcCalStrobe_n,
   input wire logic                     adcChanStrobe_n,
   input wire logic [7:0]               adcChannel,
   input wire logic                     adcBusy,
   input wire logic [11:0]              adcResult,
   input wire logic                     dacWrite_n,
   input wire logic [7:0]               motorDriveLevel,
   input wire logic                     hwFailure,
   input wire plpc_pkg::plpc_sense_en_t senseEn,
   input wire plpc_pkg::plpc_sense_in_t senseIn,
   input wire logic                     airPresent,
   input wire logic [4:0]               motorPhase
);
   // ****
   // Helpers and properties
   // ****
   localparam int STB_LAST  = STROBE_CYCLES - 1;
   localparam int HALF_LAST = ADC_HALF_CYCLES - 1;
   logic [3:0]  upperLat;
   int unsigned nmiLen;
   int unsigned dacLen;
   always_ff @(posedge clock) begin
      if (busIn.ale) upperLat <= busIn.upper;
      nmiLen <= (rst || !nonmaskableIrq) ? 0 : nmiLen + 1;
      dacLen <= (rst || dacWrite_n) ? 0 : dacLen + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_sup_reset;
      !supervisorReset_n |=> !processorReset_n;
   endproperty
   a_sup_reset: assert property (p_sup_reset) else $error("processor reset not asserted");
   property p_nmi_raise;
      !watchdogExpired_n && !nonmaskableIrq && processorReset_n && $past(processorReset_n)
         |-> ##[1:2] nonmaskableIrq;
   endproperty
   a_nmi_raise: assert property (p_nmi_raise) else $error("interrupt not raised");
   property p_nmi_len;
      $fell(nonmaskableIrq) && supervisorReset_n && !$past(rst)
         |-> nmiLen + 2 >= NMI_RESET_CYCLES && nmiLen <= NMI_RESET_CYCLES + 1 && !processorReset_n;
   endproperty
   a_nmi_len: assert property (p_nmi_len) else $error("interrupt span wrong");
   property p_go_pulse;
      $fell(adcGoStrobe_n) |-> ##STB_LAST !adcGoStrobe_n ##1 adcGoStrobe_n;
   endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("start pulse width wrong");
   property p_cal_pulse;
      $fell(adcCalStrobe_n)
         |-> (!adcCalStrobe_n throughout (1'h1 ##STB_LAST 1'h1)) ##1 adcCalStrobe_n;
   endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("calibration pulse width wrong");
   property p_dac_pulse;
      $rose(dacWrite_n) && !$past(rst) |-> dacLen == STROBE_CYCLES;
   endproperty
   a_dac_pulse: assert property (p_dac_pulse) else $error("dac strobe width wrong");
   property p_fail_off;
      hwFailure [*3] |-> motorDriveLevel == 8'h00 && motorPhase == 5'h00;
   endproperty
   a_fail_off: assert property (p_fail_off) else $error("motor not off on failure");
   property p_air;
      senseEn.bubbleDetectorPower && !senseEn.bubbleTest_n && senseIn.bubble |=> airPresent;
   endproperty
   a_air: assert property (p_air) else $error("air not flagged");
   property p_air_stop;
      airPresent [*3] |-> motorPhase == 5'h00;
   endproperty
   a_air_stop: assert property (p_air_stop) else $error("motor runs with air");
   property p_adc_half;
      $rose(adcClock) |-> ##HALF_LAST adcClock ##1 !adcClock;
   endproperty
   a_adc_half: assert property (p_adc_half) else $error("converter clock half period wrong");
   property p_read_ans;
      !busIn.ale && !busIn.select_n && !busIn.rd_n && upperLat == plpc_pkg::IO_SEGMENT |=> adOe;
   endproperty
   a_read_ans: assert property (p_read_ans) else $error("read not answered");
   c_read: cover property ($rose(adOe));
   c_nmi: cover property ($rose(nonmaskableIrq));
   c_conv: cover property ($fell(adcBusy));
   c_air: cover property ($rose(airPresent));
endmodule : plpc_pc_assertions
bind plpc_peripheral_control plpc_pc_assertions #(
   .NMI_RESET_CYCLES(NMI_RESET_CYCLES),
   .ADC_HALF_CYCLES(ADC_HALF_CYCLES),
   .STROBE_CYCLES(STROBE_CYCLES)
) chk (.*);
`default_nettype wire

// >>> verif/plpc_adc_model.sv
// Purpose: Behavioural converter on the converter pins
// Assumes: Converts only while its clock runs
// Notes:   Result is 5 in the top nibble, channel below
`timescale 1ns/100ps
`default_nettype none
module plpc_adc_model #(
   parameter int CONV_CLKS = 4
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        adcClock,
   input  wire logic        adcGoStrobe_n,
   input  wire logic        adcCalStrobe_n,
   input  wire logic        adcChanStrobe_n,
   input  wire logic [7:0]  adcChannel,
   output var  logic        adcBusy,
   output var  logic [11:0] adcResult
);
   // ****
   // Conversion engine
   // ****
   logic [7:0] chan;
   logic       clkPrev;
   int         left;
   always_ff @(posedge clock) begin
      clkPrev <= adcClock;
      // Result lines toggle while busy
      adcResult <= adcBusy ? ~adcResult : {4'h5, chan};
      if (rst) begin
         adcBusy <= 1'h0;
         left <= 0;
         chan <= 8'h00;
      end else begin
         if (!adcChanStrobe_n) chan <= adcChannel;
         if (!adcGoStrobe_n || !adcCalStrobe_n) begin
            adcBusy <= 1'h1;
            left <= CONV_CLKS;
         end else if (adcBusy && adcClock && !clkPrev) begin
            left <= left - 1;
            if (left == 1) adcBusy <= 1'h0;
         end
      end
   end
endmodule : plpc_adc_model
`default_nettype wire

// >>> verif/tb_pump_logic_peripheral_control.sv
// Purpose: Self-checking bench for the pump peripheral control block
// Assumes: Bus driven on falling edges, short timing parameters
// Notes:   Converter model answers on the converter pins
`timescale 1ns/100ps
`default_nettype none
module tb_pump_logic_peripheral_control;
   // ****
   // Signals and tasks
   // ****
   localparam logic [3:0] SEG = plpc_pkg::IO_SEGMENT;
   logic                     clock = 1'h0;
   logic                     rst = 1'h1;
   logic                     supervisorReset_n = 1'h1;
   logic                     watchdogExpired_n = 1'h1;
   logic                     hwFailure = 1'h0;
   plpc_pkg::plpc_bus_in_t   busIn = 16'h7000;
   plpc_pkg::plpc_sense_in_t senseIn = 5'h00;
   plpc_pkg::plpc_sense_en_t senseEn;
   wire logic [7:0]  adOut, adcChannel, motorDriveLevel;
   wire logic        adOe, processorReset_n, nonmaskableIrq, adcClock, adcGoStrobe_n;
   wire logic        adcCalStrobe_n, adcChanStrobe_n, adcBusy, dacWrite_n, airPresent;
   wire logic [11:0] adcResult;
   wire logic [4:0]  motorPhase;
   int n_errors = 0, tests_run = 0, nGo = 0, nCal = 0, nChan = 0, nDac = 0, nClk = 0;
   realtime tRise = 0, period = 0;
   plpc_peripheral_control #(.NMI_RESET_CYCLES(50), .STEP_TICK_CYCLES(4), .ADC_HALF_CYCLES(75),
      .STROBE_CYCLES(20)) uut (.*);
   plpc_adc_model adc (.*);
   always #2.5 clock = ~clock;
   always @(negedge adcGoStrobe_n) nGo++;
   always @(negedge adcCalStrobe_n) nCal++;
   always @(negedge adcChanStrobe_n) nChan++;
   always @(negedge dacWrite_n) nDac++;
   always @(posedge adcClock) begin
      period = $realtime - tRise;
      tRise = $realtime;
      nClk++;
   end
   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc
   task automatic busWrite(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      busIn = {4'hF, SEG, addr};
      @(negedge clock);
      busIn = {4'h4, SEG, data};
      @(negedge clock);
      busIn = {4'h7, SEG, data};
   endtask : busWrite
   task automatic busRead(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clock);
      busIn = {4'hF, SEG, addr};
      @(negedge clock);
      busIn = {4'h2, SEG, 8'h00};
      cyc(2);
      data = adOut;
      check("read enable", 12'h001, {11'h000, adOe});
      busIn = {4'h7, SEG, 8'h00};
   endtask : busRead
   task automatic waitIdle;
      logic [7:0] s;
      int k;
      s = 8'h01;
      for (k = 0; k < 200 && s[0] !== 1'h0; k++) busRead(plpc_pkg::PORT_ADC_CTRL, s);
      check("converter busy", 12'h000, {11'h000, s[0]});
   endtask : waitIdle
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   initial begin
      #100us;
      n_errors++;
      results();
   end
   // ****
   // Test sequence
   // ****
   initial begin
      logic [7:0] rd;
      logic [4:0] ph;
      logic [4:0] ex;
      int i;
      int k;
      cyc(10);
      rst = 1'h0;
      cyc(2);
      check("processor reset", 12'h001, {11'h000, processorReset_n});
      supervisorReset_n = 1'h0;
      cyc(2);
      check("supervisor reset", 12'h000, {11'h000, processorReset_n});
      supervisorReset_n = 1'h1;
      check("sense enables", {7'h00, plpc_pkg::SENSE_EN_RESET}, {7'h00, senseEn});
      busRead(8'h09, rd);
      check("unmapped read", 12'h000, {4'h0, rd});
      $display("test reset done");
      busWrite(plpc_pkg::PORT_ADC_CTRL, 8'h02);
      cyc(200);
      check("start while clock off", 12'h000, 12'(nGo));
      check("clock while off", 12'h000, 12'(nClk));
      busWrite(plpc_pkg::PORT_ADC_CTRL, 8'h01);
      cyc(400);
      check("converter period", 12'h2EE, 12'(int'(period)));
      busWrite(plpc_pkg::PORT_ADC_CHAN, 8'h07);
      cyc(25);
      check("channel strobe", 12'h001, 12'(nChan));
      check("channel out", 12'h007, {4'h0, adcChannel});
      busWrite(plpc_pkg::PORT_ADC_CTRL, 8'h03);
      waitIdle();
      check("start pulse", 12'h001, 12'(nGo));
      busRead(plpc_pkg::PORT_ADC_LOW, rd);
      check("result low", 12'h007, {4'h0, rd});
      busRead(plpc_pkg::PORT_ADC_HIGH, rd);
      check("result high", 12'h005, {4'h0, rd});
      busWrite(plpc_pkg::PORT_ADC_CTRL, 8'h05);
      waitIdle();
      check("calibration pulse", 12'h001, 12'(nCal));
      check("no extra start", 12'h001, 12'(nGo));
      $display("test converter done");
      busWrite(plpc_pkg::PORT_DAC, 8'hA5);
      cyc(2);
      check("dac strobe", 12'h001, 12'(nDac));
      check("drive level", 12'h0A5, {4'h0, motorDriveLevel});
      hwFailure = 1'h1;
      cyc(3);
      check("drive on failure", 12'h000, {4'h0, motorDriveLevel});
      hwFailure = 1'h0;
      cyc(25);
      senseIn = 5'h1F;
      busWrite(plpc_pkg::PORT_SENSE_EN, 8'h1F);
      busRead(plpc_pkg::PORT_SENSE_IN, rd);
      check("inputs test high", 12'h0DF, {4'h0, rd});
      check("air with test high", 12'h000, {11'h000, airPresent});
      busWrite(plpc_pkg::PORT_SENSE_EN, 8'h1D);
      busRead(plpc_pkg::PORT_SENSE_IN, rd);
      check("inputs all valid", 12'h0FF, {4'h0, rd});
      check("enables", 12'h01D, {7'h00, senseEn});
      check("air present", 12'h001, {11'h000, airPresent});
      busWrite(plpc_pkg::PORT_SENSE_EN, 8'h10);
      busRead(plpc_pkg::PORT_SENSE_IN, rd);
      check("inputs pressure only", 12'h01F, {4'h0, rd});
      busRead(plpc_pkg::PORT_ADC_CTRL, rd);
      check("pressure supply status", 12'h006, {4'h0, rd});
      $display("test sensors done");
      senseIn = 5'h1B;
      busWrite(plpc_pkg::PORT_MOTOR_RATE, 8'h01);
      for (i = 0; i < 6; i++) begin
         ph = motorPhase;
         for (k = 0; k < 50 && motorPhase === ph; k++) cyc(1);
         ex = (ph === 5'h00) ? plpc_pkg::PHASE_START : {ph[3:0], ph[4]};
         check("phase step", {7'h00, ex}, {7'h00, motorPhase});
      end
      hwFailure = 1'h1;
      cyc(3);
      check("phases on failure", 12'h000, {7'h00, motorPhase});
      hwFailure = 1'h0;
      senseIn = 5'h1F;
      busWrite(plpc_pkg::PORT_SENSE_EN, 8'h01);
      cyc(4);
      check("phases with air", 12'h000, {7'h00, motorPhase});
      busWrite(plpc_pkg::PORT_MOTOR_RATE, 8'h00);
      $display("test motor done");
      watchdogExpired_n = 1'h0;
      cyc(3);
      check("interrupt raised", 12'h001, {11'h000, nonmaskableIrq});
      check("reset not yet", 12'h001, {11'h000, processorReset_n});
      watchdogExpired_n = 1'h1;
      cyc(60);
      check("interrupt ended", 12'h000, {11'h000, nonmaskableIrq});
      check("reset held", 12'h000, {11'h000, processorReset_n});
      supervisorReset_n = 1'h0;
      cyc(3);
      check("supervisor reset", 12'h000, {11'h000, processorReset_n});
      supervisorReset_n = 1'h1;
      cyc(3);
      // processor free to reset safety side
      check("reset released", 12'h001, {11'h000, processorReset_n});
      $display("test watchdog done");
      results();
   end
endmodule : tb_pump_logic_peripheral_control
`default_nettype wire
